// *** hdl/scd_pkg.sv ***
// Package: constants for the sinc3 decimator and channel configuration block
package scd_pkg;
  localparam int unsigned NUM_CHAN = 8;
  localparam int unsigned OUT_W = 16;
  localparam int unsigned ACC_W = 36;
  localparam int unsigned CLK_FREQ_HZ = 100000000;
  localparam logic [2:0] MOD_DIV = 3'h7;
  localparam logic [2:0] SEL_NORMAL = 3'h0;
  localparam logic [2:0] SEL_SHORT = 3'h1;
  localparam logic [2:0] SEL_DRIVE = 3'h2;
  localparam logic [2:0] SEL_SUPPLY = 3'h3;
  localparam logic [2:0] SEL_TEMP = 3'h4;
  localparam logic [2:0] SEL_TEST = 3'h5;
  localparam logic [2:0] GAIN_ONE = 3'h0;
  localparam logic [2:0] GAIN_MAX_CODE = 3'h6;
  localparam logic [2:0] RATE_RESET = 3'h6;
  localparam int unsigned SETTLE_PERIODS = 3;
  localparam logic [3:0] ADDR_CONFIG_REG_TWO = 4'h0;
  localparam logic [3:0] ADDR_CONFIG_REG_THREE = 4'h1;
  localparam logic [3:0] ADDR_CH_BASE = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [7:0] CHSET_RESET = 8'h00;
  localparam int unsigned CFG3_MEAS_BIT = 0;
  localparam int unsigned CFG2_START_BIT = 3;
  localparam logic signed [ACC_W-1:0] SAT_POS = 36'sh0_0000_7fff;
  localparam logic signed [ACC_W-1:0] SAT_NEG = -36'sh0_0000_8000;
  // Decimation ratio for each rate code; 8 down to 1024
  function automatic logic [10:0] rate_to_ratio(input logic [2:0] code);
    logic [10:0] r;
    r = 11'h008;
    case (code)
      3'h0: r = 11'h008;
      3'h1: r = 11'h010;
      3'h2: r = 11'h020;
      3'h3: r = 11'h040;
      3'h4: r = 11'h080;
      3'h5: r = 11'h100;
      3'h6: r = 11'h200;
      default: r = 11'h400;
    endcase
    return r;
  endfunction
  // Right shift of log2(N^3) minus 3, so a full-scale N^3 sum comes out as 8
  function automatic logic [5:0] rate_to_shift(input logic [2:0] code);
    return 6'(3 * (int'(code) + 3) - 3);
  endfunction
endpackage

// *** hdl/scd_mod_enable.sv ***
// Divider: modulator-rate enable, one pulse per eight clocks
`timescale 1ns/100ps
`default_nettype none
module scd_mod_enable
  import scd_pkg::*;
(
  input wire logic i_core_clk, // Core clock
  input wire logic i_rst_n,    // Sync reset, active low
  output logic o_mod_en        // One-cycle modulator strobe
);
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic en_q;
  assign cnt_d = (cnt_q == MOD_DIV) ? 3'h0 : cnt_q + 3'h1;
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      cnt_q <= 3'h0;
      en_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      en_q <= (cnt_q == MOD_DIV);
    end
  end
  assign o_mod_en = en_q;
endmodule
`default_nettype wire

// *** hdl/scd_sinc3.sv ***
// One channel of the third-order sinc decimation filter
`timescale 1ns/100ps
`default_nettype none
module scd_sinc3
  import scd_pkg::*;
(
  input wire logic i_core_clk,          // Core clock
  input wire logic i_rst_n,             // Sync reset, active low
  input wire logic i_clear,             // Flush filter memory
  input wire logic i_mod_en,            // Modulator-rate strobe
  input wire logic i_bit,               // Modulator bitstream
  input wire logic i_dec_en,            // Decimation strobe
  input wire logic [5:0] i_shift,       // Output scaling
  output logic signed [OUT_W-1:0] o_word // Saturated output word
);
  logic signed [ACC_W-1:0] in_s;
  logic signed [ACC_W-1:0] i1_q, i2_q, i3_q;
  logic signed [ACC_W-1:0] d1_q, d2_q, d3_q;
  logic signed [ACC_W-1:0] c1, c2, c3, scaled;
  logic signed [OUT_W-1:0] word_q, sat;
  // Bit 1 means +1, bit 0 means -1
  assign in_s = i_bit ? 36'sh0_0000_0001 : -36'sh0_0000_0001;
  // comb section of cube of (1-z^-N)/(1-z^-1)
  assign c1 = i3_q - d1_q;
  assign c2 = c1 - d2_q;
  assign c3 = c2 - d3_q;
  assign scaled = c3 >>> i_shift;
  assign sat = (scaled > SAT_POS) ? 16'sh7fff :
               (scaled < SAT_NEG) ? -16'sh8000 : scaled[OUT_W-1:0];
  // Wraparound is harmless: modular arithmetic cancels in the combs
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || i_clear) begin
      i1_q <= '0;
      i2_q <= '0;
      i3_q <= '0;
    end else if (i_mod_en) begin
      i1_q <= i1_q + in_s;
      i2_q <= i2_q + i1_q;
      i3_q <= i3_q + i2_q;
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || i_clear) begin
      d1_q <= '0;
      d2_q <= '0;
      d3_q <= '0;
      word_q <= '0;
    end else if (i_dec_en) begin
      d1_q <= i3_q;
      d2_q <= c1;
      d3_q <= c2;
      word_q <= sat;
    end
  end
  assign o_word = word_q;
endmodule
`default_nettype wire

// *** hdl/scd_top.sv ***
// Top: eight-channel sinc3 conversion path with channel configuration registers
// ==========================================================================
// Overview of operation
// - The modulator strobe fires once every eight core clocks.
// - Each channel filters its bitstream with three integrators and three combs.
// - One shared rate field sets the decimation ratio of all channels.
// - Each channel yields one word per N modulator samples.
// - A step settles within three output periods, the filter depth.
// - After start rises, output is held back for the settling interval.
// - The boxcar structure puts nulls at the output rate and its multiples.
// - Input code 011 routes a channel to its supply monitor, by channel.
// - Input code 010 with the measure bit set picks the drive input pin.
// - Seven gain codes are accepted per channel settings register.
// - Words are 16-bit two's complement, clipped at full scale.
// ==========================================================================
`timescale 1ns/100ps
`default_nettype none
module scd_top
  import scd_pkg::*;
(
  input wire logic i_core_clk,                   // Core clock, 100 MHz
  input wire logic i_rst_n,                      // Sync reset, active low
  input wire logic [3:0] i_addr,                 // Register address
  input wire logic [7:0] i_wdata,                // Write data
  input wire logic i_wr,                         // Write strobe
  input wire logic i_rd,                         // Read strobe
  output logic [7:0] o_rdata,                    // Read data, one cycle later
  input wire logic [NUM_CHAN-1:0] i_mod_bits,    // Modulator bits, one per channel
  output logic o_mod_en,                         // Modulator sampling strobe
  output logic [NUM_CHAN*OUT_W-1:0] o_samples,   // Packed sample words
  output logic o_sample_valid,                   // One-cycle new-data pulse
  output logic o_data_ready_n,                   // Low while unread data waits
  output logic [NUM_CHAN*3-1:0] o_mux_sel,       // Per-channel mux route code
  output logic [NUM_CHAN*3-1:0] o_gain_sel       // Per-channel gain code
);
  // Route codes presented to the analog mux
  localparam logic [2:0] ROUTE_NORMAL = 3'h0;
  localparam logic [2:0] ROUTE_SHORT = 3'h1;
  localparam logic [2:0] ROUTE_DRIVE_AUX = 3'h2;
  localparam logic [2:0] ROUTE_SUPPLY_ANALOG = 3'h3;
  localparam logic [2:0] ROUTE_SUPPLY_DIGITAL = 3'h4;
  localparam logic [2:0] ROUTE_TEMP = 3'h5;
  localparam logic [2:0] ROUTE_TEST = 3'h6;
  localparam logic [2:0] ROUTE_OPEN = 3'h7;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SETTLE = 2'b01,
    ST_RUN = 2'b10
  } scd_state_type;

  // ==========================================================================
  // Registers
  logic [7:0] config_reg_two_q;
  logic [7:0] config_reg_three_q;
  logic [7:0] channel_settings_reg_q [NUM_CHAN];
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [2:0] rate_select_field;
  logic drive_input_measure_sel;
  logic start_bit;
  logic start_q;
  logic start_rise;
  logic wr_cfg2;
  logic wr_cfg3;
  logic ch_hit;
  logic [2:0] ch_idx;
  logic [7:0] status;
  logic hit_cfg2;
  logic hit_cfg3;
  logic hit_status;
  logic rd_status;

  // ==========================================================================
  // Address decode
  assign hit_cfg2 = (i_addr == ADDR_CONFIG_REG_TWO);
  assign hit_cfg3 = (i_addr == ADDR_CONFIG_REG_THREE);
  assign hit_status = (i_addr == ADDR_STATUS);
  // Channel block is eight consecutive addresses
  assign ch_hit = (i_addr >= ADDR_CH_BASE) && (i_addr < ADDR_CH_BASE + 4'(NUM_CHAN));
  assign ch_idx = 3'(i_addr - ADDR_CH_BASE);
  assign wr_cfg2 = i_wr && hit_cfg2;
  assign wr_cfg3 = i_wr && hit_cfg3;
  // Reading status is what acknowledges pending data
  assign rd_status = i_rd && hit_status;

  // ==========================================================================
  // Configuration fields
  assign rate_select_field = config_reg_two_q[2:0];
  assign start_bit = config_reg_two_q[CFG2_START_BIT];
  assign drive_input_measure_sel = config_reg_three_q[CFG3_MEAS_BIT];

  // only seven gain codes; higher codes fold to unity
  function automatic logic [7:0] legal_chset(input logic [7:0] v);
    logic [7:0] r;
    r = v;
    if (v[6:4] > GAIN_MAX_CODE) begin
      r[6:4] = GAIN_ONE;
    end
    return r;
  endfunction

  // Writes land on the edge that samples the strobe
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      config_reg_two_q <= {5'h00, RATE_RESET};
      config_reg_three_q <= 8'h00;
    end else begin
      if (wr_cfg2) begin
        config_reg_two_q <= i_wdata;
      end
      if (wr_cfg3) begin
        config_reg_three_q <= i_wdata;
      end
    end
  end

  // One write port; the address picks the channel
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      for (int k = 0; k < NUM_CHAN; k++) begin
        channel_settings_reg_q[k] <= CHSET_RESET;
      end
    end else if (i_wr && ch_hit) begin
      channel_settings_reg_q[ch_idx] <= legal_chset(i_wdata);
    end
  end

  // ==========================================================================
  // Conversion control
  scd_state_type state_q;
  scd_state_type state_d;
  logic [10:0] ratio;
  logic [5:0] shift;
  logic [10:0] dec_cnt_q;
  logic [10:0] dec_cnt_d;
  logic [1:0] settle_cnt_q;
  logic [1:0] settle_cnt_d;
  logic dec_en;
  logic filt_clear;
  logic valid_q;
  logic ready_n_q;
  logic rate_chg;
  logic [2:0] rate_q;
  logic take_word;

  assign ratio = rate_to_ratio(rate_q);
  assign shift = rate_to_shift(rate_q);
  assign start_rise = start_bit && !start_q;
  // Compared with last cycle's copy, so a change is caught exactly once
  assign rate_chg = (rate_select_field != rate_q);
  // Rate change restarts the filters so no word mixes two ratios
  assign filt_clear = start_rise || rate_chg || !start_bit;
  // Decimation point on the N-th modulator pulse since the last one
  assign dec_en = o_mod_en && (dec_cnt_q == ratio - 11'h001) && (state_q != ST_IDLE);
  // Counter restarts with the filters so every word spans whole blocks
  assign dec_cnt_d = filt_clear ? 11'h000 :
                     !o_mod_en ? dec_cnt_q :
                     (dec_cnt_q == ratio - 11'h001) ? 11'h000 : dec_cnt_q + 11'h001;

  // ==========================================================================
  // Settling control
  // hold back first words until settled
  always_comb begin
    state_d = state_q;
    settle_cnt_d = settle_cnt_q;
    case (state_q)
      ST_IDLE: begin
        // Nothing runs until the start bit is set
        settle_cnt_d = 2'h0;
        if (start_bit) begin
          state_d = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        // Discard the words that still hold pre-start history
        if (dec_en) begin
          settle_cnt_d = settle_cnt_q + 2'h1;
          if (settle_cnt_q == 2'(SETTLE_PERIODS - 1)) begin
            state_d = ST_RUN;
          end
        end
      end
      ST_RUN: begin
        // Free running until the next flush
        settle_cnt_d = settle_cnt_q;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // A flush overrides any state: settling starts over
    if (filt_clear) begin
      state_d = start_bit ? ST_SETTLE : ST_IDLE;
      settle_cnt_d = 2'h0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      state_q <= ST_IDLE;
      settle_cnt_q <= 2'h0;
      dec_cnt_q <= 11'h000;
      start_q <= 1'b0;
      rate_q <= RATE_RESET;
    end else begin
      state_q <= state_d;
      settle_cnt_q <= settle_cnt_d;
      dec_cnt_q <= dec_cnt_d;
      start_q <= start_bit;
      rate_q <= rate_select_field;
    end
  end

  // ==========================================================================
  // Data-ready flag
  // Only words taken after settling count as new data
  assign take_word = dec_en && (state_q == ST_RUN);

  // New data flag: set wins over clear by read
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      valid_q <= 1'b0;
      ready_n_q <= 1'b1;
    end else begin
      valid_q <= take_word;
      if (take_word) begin
        ready_n_q <= 1'b0;
      end else if (rd_status) begin
        ready_n_q <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Channels
  logic [NUM_CHAN*OUT_W-1:0] words;
  logic [NUM_CHAN*OUT_W-1:0] samples_q;
  logic [NUM_CHAN*3-1:0] mux_q;
  logic [NUM_CHAN*3-1:0] mux_d;
  logic [NUM_CHAN*3-1:0] gain_q;

  // Shared strobe keeps every channel on the same sample instant
  scd_mod_enable u_mod_en (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .o_mod_en(o_mod_en)
  );

  // nulls follow from the N-tap boxcar combs
  for (genvar g = 0; g < NUM_CHAN; g++) begin : g_chan
    logic [2:0] sel;
    logic supply_digital;
    assign sel = channel_settings_reg_q[g][2:0];
    // Channels 3 and 4 watch the digital supply instead
    assign supply_digital = (g == 2) || (g == 3);
    scd_sinc3 u_filt (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_clear(filt_clear),
      .i_mod_en(o_mod_en),
      .i_bit(i_mod_bits[g]),
      .i_dec_en(dec_en),
      .i_shift(shift),
      .o_word(words[g*OUT_W +: OUT_W])
    );
    // supply monitor differs for channels 3 and 4
    // drive input needs code 010 and the measure bit
    assign mux_d[g*3 +: 3] =
      (sel == SEL_NORMAL) ? ROUTE_NORMAL :
      (sel == SEL_SHORT) ? ROUTE_SHORT :
      (sel == SEL_DRIVE && drive_input_measure_sel) ? ROUTE_DRIVE_AUX :
      (sel == SEL_SUPPLY && supply_digital) ? ROUTE_SUPPLY_DIGITAL :
      (sel == SEL_SUPPLY) ? ROUTE_SUPPLY_ANALOG :
      (sel == SEL_TEMP) ? ROUTE_TEMP :
      (sel == SEL_TEST) ? ROUTE_TEST : ROUTE_OPEN;
  end

  // ==========================================================================
  // Output registers
  // All eight words move on one edge, so a reader never sees a mixed set
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      samples_q <= '0;
    end else if (take_word) begin
      samples_q <= words;
    end
  end

  // gain is passed as stored, code 7 already folded to unity; software keeps unity for supply monitoring
  // Registered route codes keep decode glitches off the analog switches
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      mux_q <= '0;
      gain_q <= '0;
    end else begin
      mux_q <= mux_d;
      for (int k = 0; k < NUM_CHAN; k++) begin
        gain_q[k*3 +: 3] <= channel_settings_reg_q[k][6:4];
      end
    end
  end

  // ==========================================================================
  // Read path, data one cycle after the strobe
  // Status: running, pending, then the two state bits
  assign status = {4'h0, state_q == ST_RUN, ~ready_n_q, state_q};
  // Idle cycles and unmapped addresses read as zero
  always_comb begin
    rdata_d = 8'h00;
    if (!i_rd) begin
      rdata_d = 8'h00;
    end else if (hit_cfg2) begin
      rdata_d = config_reg_two_q;
    end else if (hit_cfg3) begin
      rdata_d = config_reg_three_q;
    end else if (hit_status) begin
      rdata_d = status;
    end else if (ch_hit) begin
      rdata_d = channel_settings_reg_q[ch_idx];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================================
  // Outputs, each straight from a flip-flop
  assign o_rdata = rdata_q;
  assign o_samples = samples_q;
  assign o_sample_valid = valid_q;
  assign o_data_ready_n = ready_n_q;
  assign o_mux_sel = mux_q;
  assign o_gain_sel = gain_q;
endmodule
`default_nettype wire

// *** tb/scd_top_properties.sv ***
// Checker: port-level timing, gain and routing properties of the sinc3 conversion path
`timescale 1ns/100ps
`default_nettype none
module scd_top_properties
  import scd_pkg::*;
(
  input wire logic i_core_clk, // Core clock
  input wire logic i_rst_n, // Sync reset, active low
  input wire logic [3:0] i_addr, // Register address
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  input wire logic [7:0] i_wdata, // Write data
  input wire logic [7:0] o_rdata, // Read data
  input wire logic o_mod_en, // Modulator strobe
  input wire logic [NUM_CHAN*OUT_W-1:0] o_samples, // Packed words
  input wire logic o_sample_valid, // New-data pulse
  input wire logic o_data_ready_n, // Data pending, active low
  input wire logic [NUM_CHAN*3-1:0] o_mux_sel, // Route codes
  input wire logic [NUM_CHAN*3-1:0] o_gain_sel // Gain codes
);
  // ====
  // Helper state
  logic [2:0] rate_q;
  logic [16:0] gap_q;
  logic [15:0] mcnt_q;
  logic prev_q;
  logic gain7;
  logic bad_route;
  wire cfg_wr = i_wr && (i_addr == ADDR_CONFIG_REG_TWO);
  // A config reg two write may restart settling, so period checks start over
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      rate_q <= RATE_RESET;
      gap_q <= '0;
      mcnt_q <= '0;
      prev_q <= 1'b0;
    end else begin
      if (cfg_wr) rate_q <= i_wdata[2:0];
      gap_q <= o_sample_valid ? 17'h00001 : gap_q + 17'h00001;
      mcnt_q <= cfg_wr ? 16'h0000 : mcnt_q + {15'h0000, o_mod_en && (mcnt_q != 16'hffff)};
      prev_q <= !cfg_wr && (prev_q || o_sample_valid);
    end
  end
  always_comb begin
    gain7 = 1'b0;
    bad_route = 1'b0;
    for (int g = 0; g < NUM_CHAN; g++) begin
      if (o_gain_sel[g*3+:3] == 3'h7) gain7 = 1'b1;
      if (o_mux_sel[g*3+:3] == ((g == 2 || g == 3) ? 3'h3 : 3'h4)) bad_route = 1'b1;
    end
  end
  // ====
  // Properties
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_status_rd;
    i_rd && (i_addr == ADDR_STATUS);
  endsequence
  sequence s_quiet2;
    !o_sample_valid ##1 !o_sample_valid;
  endsequence
  AST_MOD_PERIOD: assert property (o_mod_en |=> !o_mod_en [*7] ##1 o_mod_en)
    else $error("modulator strobe spacing wrong");
  AST_OUT_PERIOD: assert property ((o_sample_valid && prev_q) |-> gap_q == (17'h40 << rate_q))
    else $error("output word spacing wrong");
  AST_SETTLE: assert property (o_sample_valid |-> mcnt_q >= (16'h20 << rate_q))
    else $error("output word before settling");
  AST_VALID_PULSE: assert property (o_sample_valid |=> !o_sample_valid)
    else $error("valid longer than one cycle");
  AST_HOLD: assert property (!o_sample_valid |-> $stable(o_samples))
    else $error("samples moved without valid");
  AST_DRDY_SET: assert property (o_sample_valid |-> !o_data_ready_n)
    else $error("ready not flagged with new data");
  AST_DRDY_CLEAR: assert property (s_status_rd ##1 s_quiet2 |-> o_data_ready_n)
    else $error("ready not cleared by status read");
  AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside answer cycle");
  AST_GAIN_CODES: assert property (!gain7)
    else $error("gain code out of range");
  AST_SUPPLY_ROUTE: assert property (!bad_route)
    else $error("supply route on wrong channel");
endmodule
bind scd_top scd_top_properties u_props (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_mod_en(o_mod_en),
  .o_samples(o_samples), .o_sample_valid(o_sample_valid), .o_data_ready_n(o_data_ready_n),
  .o_mux_sel(o_mux_sel), .o_gain_sel(o_gain_sel));
`default_nettype wire

// *** tb/scd_consumer.sv ***
// Partner: sample consumer capturing each new word set
`timescale 1ns/100ps
`default_nettype none
module scd_consumer
  import scd_pkg::*;
(
  input wire logic i_core_clk, // Core clock
  input wire logic i_rst_n, // Sync reset, active low
  input wire logic i_valid, // New-data pulse
  input wire logic [NUM_CHAN*OUT_W-1:0] i_samples, // Packed words
  output logic [15:0] o_count, // Sets captured
  output logic [16:0] o_gap, // Cycles between last two pulses
  output logic [NUM_CHAN*OUT_W-1:0] o_words // Last set
);
  logic [16:0] run_q;
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_count <= '0;
      o_gap <= '0;
      run_q <= '0;
      o_words <= '0;
    end else begin
      run_q <= i_valid ? 17'h00001 : run_q + 17'h00001;
      if (i_valid) begin
        o_count <= o_count + 16'h0001;
        o_gap <= run_q;
        o_words <= i_samples;
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/scd_top_tb.sv ***
// Testbench: register, routing and conversion checks for the sinc3 block
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin bad_count++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); end end
module scd_top_tb
  import scd_pkg::*;
;
  logic i_core_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [NUM_CHAN-1:0] i_mod_bits = 8'h0f;
  logic [7:0] o_rdata;
  logic o_mod_en, o_sample_valid, o_data_ready_n;
  logic [NUM_CHAN*OUT_W-1:0] o_samples, p_words;
  logic [NUM_CHAN*3-1:0] o_mux_sel, o_gain_sel;
  logic [15:0] p_count;
  logic [16:0] p_gap;
  int bad_count = 0;
  int checks_done = 0;
  localparam logic [28:0] ROWS [12] = '{
    {4'h4, 8'h03, 8'h03, 3'h0, 3'h3, 3'h0}, {4'h6, 8'h03, 8'h03, 3'h2, 3'h4, 3'h0},
    {4'h7, 8'h03, 8'h03, 3'h3, 3'h4, 3'h0}, {4'h8, 8'h60, 8'h60, 3'h4, 3'h0, 3'h6},
    {4'h5, 8'h72, 8'h02, 3'h1, 3'h7, 3'h0}, {4'h9, 8'h11, 8'h11, 3'h5, 3'h1, 3'h1},
    {4'ha, 8'h24, 8'h24, 3'h6, 3'h5, 3'h2}, {4'hb, 8'h35, 8'h35, 3'h7, 3'h6, 3'h3},
    {4'hb, 8'h46, 8'h46, 3'h7, 3'h7, 3'h4}, {4'hb, 8'h57, 8'h57, 3'h7, 3'h7, 3'h5},
    {4'h4, 8'h80, 8'h80, 3'h0, 3'h0, 3'h0}, {4'h9, 8'h03, 8'h03, 3'h5, 3'h3, 3'h0}};
  always #5 i_core_clk = ~i_core_clk;
  scd_top u_dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_mod_bits(i_mod_bits),
    .o_mod_en(o_mod_en), .o_samples(o_samples), .o_sample_valid(o_sample_valid),
    .o_data_ready_n(o_data_ready_n), .o_mux_sel(o_mux_sel), .o_gain_sel(o_gain_sel));
  scd_consumer u_sink (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_valid(o_sample_valid),
    .i_samples(o_samples), .o_count(p_count), .o_gap(p_gap), .o_words(p_words));
  // ====
  // Bus and wait tasks
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge i_core_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge i_core_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask
  task automatic wait_sets(input int k);
    logic [15:0] n0;
    n0 = p_count;
    for (int i = 0; i < 20000 && p_count < n0 + 16'(k); i++) begin
      @(posedge i_core_clk);
      #1;
    end
    `CHK(p_count, n0 + 16'(k))
  endtask
  task automatic results;
    $display("checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Run is about 6k cycles; the limit leaves wide margin
  initial begin
    #200us;
    bad_count++;
    results;
  end
  initial begin
    logic [7:0] d;
    logic [15:0] w;
    repeat (2) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    #1 `CHK(o_data_ready_n, 1'b1)
    rd(ADDR_CONFIG_REG_TWO, d);
    `CHK(d, 8'h06)
    rd(4'hf, d);
    `CHK(d, 8'h00)
    $display("test reset done");
    foreach (ROWS[i]) begin
      wr(ROWS[i][28:25], ROWS[i][24:17]);
      rd(ROWS[i][28:25], d);
      `CHK(d, ROWS[i][16:9])
      `CHK(o_mux_sel[ROWS[i][8:6]*3+:3], ROWS[i][5:3])
      `CHK(o_gain_sel[ROWS[i][8:6]*3+:3], ROWS[i][2:0])
    end
    wr(ADDR_CONFIG_REG_THREE, 8'h01);
    wr(ADDR_CH_BASE + 4'h1, 8'h02);
    rd(ADDR_CONFIG_REG_THREE, d);
    `CHK(d, 8'h01)
    `CHK(o_mux_sel[5:3], 3'h2)
    $display("test registers done");
    for (int c = 0; c < 3; c++) begin
      wr(ADDR_CONFIG_REG_TWO, 8'h08 | 8'(c));
      wait_sets(2);
      `CHK(p_gap, 17'h40 << c)
    end
    `CHK(p_words[15], 1'b0)
    `CHK(p_words[79], 1'b1)
    `CHK(p_words[15:0], p_words[31:16])
    `CHK(p_words[15:0] != 16'h0000, 1'b1)
    @(posedge i_core_clk);
    i_mod_bits <= 8'hf0;
    wait_sets(4);
    w = p_words[15:0];
    `CHK(w[15], 1'b1)
    `CHK(p_words[79], 1'b0)
    wait_sets(1);
    `CHK(p_words[15:0], w)
    `CHK(o_data_ready_n, 1'b0)
    rd(ADDR_STATUS, d);
    `CHK(d, 8'h0e)
    @(posedge i_core_clk);
    #1 `CHK(o_data_ready_n, 1'b1)
    // Square wave of one output period sums to zero in every block
    for (int t = 0; t < 10; t++) begin
      repeat (128) @(posedge i_core_clk);
      i_mod_bits <= ~i_mod_bits;
    end
    #1 `CHK(p_words, '0)
    wr(ADDR_CONFIG_REG_TWO, 8'h02);
    repeat (4) @(posedge i_core_clk);
    w = p_count;
    repeat (600) @(posedge i_core_clk);
    `CHK(p_count, w)
    $display("test conversion done");
    results;
  end
endmodule
`default_nettype wire
